/* File: design/tos_pkg.sv */
// Behaviour
// RULE_01 - outputs change when entry time comes due
// RULE_02 - four outputs, each with status lamp
// RULE_03 - queue holds at most 31 entries
// RULE_04 - write window of 5 or 15 entries
// RULE_05 - entry: time, output byte, sequence number
// RULE_06 - full queue refuses and drops entries
// RULE_07 - host checks queue code before writing
// RULE_08 - four status bytes presented to host
// RULE_09 - byte0: last accepted sequence, bits 01
// RULE_10 - byte1: next executed sequence, bits 11
// RULE_11 - code 00h after successful store
// RULE_12 - code 01h: no entry or bad sequence
// RULE_13 - code 02h: no new entries queued
// RULE_14 - code 03h: queue full
// RULE_15 - entries after bit6 terminator are ignored
// RULE_16 - terminator queued: code ored with 80h
// RULE_17 - byte3 shows current queued entry count
// RULE_18 - host numbers entries 1,2,.. modulo 64
// RULE_19 - 32-bit microsecond ticker, low word compared
// RULE_20 - output byte bits 7..4 drive channels 0..3
// RULE_21 - empty queue holds last applied outputs
package tos_pkg;
	// microsecond ticker timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_PERIOD_NS = 1000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);
	// sizes
	localparam int CHANNELS = 4;
	localparam int ENTRY_BYTES = 4;
	localparam int ENTRY_W = 8 * ENTRY_BYTES;
	localparam int QUEUE_AW = 5;
	localparam int QUEUE_SLOTS = 32;
	localparam logic [5:0] QUEUE_CAP = 6'h1F;
	localparam int INGRESS_DEPTH = 4;
	localparam logic [3:0] WIN_SHORT = 4'h5;
	localparam logic [3:0] WIN_LONG = 4'hF;
	// status byte offsets in the input area
	localparam logic [1:0] OFS_LAST = 2'h0;
	localparam logic [1:0] OFS_NEXT = 2'h1;
	localparam logic [1:0] OFS_CODE = 2'h2;
	localparam logic [1:0] OFS_COUNT = 2'h3;
	// fields and fixed values
	localparam int SEQ_TERM_BIT = 6;
	localparam int OUT_CH0_BIT = 7;
	localparam logic [7:0] LAST_FIX = 8'h40;
	localparam logic [7:0] NEXT_FIX = 8'hC0;
	localparam logic [7:0] TERM_FLAG = 8'h80;
	localparam logic [5:0] SEQ_RESET = 6'h00;
	localparam logic [7:0] CODE_OK = 8'h00;
	localparam logic [7:0] CODE_NONE = 8'h01;
	localparam logic [7:0] CODE_IDLE = 8'h02;
	localparam logic [7:0] CODE_FULL = 8'h03;
	localparam logic [7:0] CODE_RESET = CODE_IDLE;
	localparam logic [3:0] OUT_RESET = 4'h0;
	// one entry as written into the output area
	typedef struct packed {
		logic [7:0] output_state_byte;
		logic [7:0] sequence_number;
		logic [15:0] entry_time_value;
	} tos_entry_t;
	// the four-byte input area, byte 0 in the top bits
	typedef struct packed {
		logic [7:0] last_accepted_sequence;
		logic [7:0] next_executed_sequence;
		logic [7:0] queue_state_code;
		logic [7:0] queued_entry_count;
	} tos_status_t;
endpackage : tos_pkg

/* File: design/tos_scheduler.sv */
`timescale 1ns/10ps
// small ingress buffer between host writes and the queue
module tos_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH]; // storage words
	logic [AW-1:0] wr_ptr; // next slot to fill
	logic [AW-1:0] rd_ptr; // oldest word
	logic [CW-1:0] count; // words held
	logic ready_q; // registered room flag

	wire do_wr = in_valid_i && ready_q;
	wire do_rd = out_valid_o && out_ready_i;
	wire [CW-1:0] next_count = count + CW'(do_wr) - CW'(do_rd);
	wire [AW-1:0] next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + AW'(1);
	wire [AW-1:0] next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + AW'(1);

	assign in_ready_o = ready_q;
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];

	// pointers, fill level and room flag
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			ready_q <= 1'b0;
		end else begin
			wr_ptr <= do_wr ? next_wr_ptr : wr_ptr;
			rd_ptr <= do_rd ? next_rd_ptr : rd_ptr;
			count <= next_count;
			ready_q <= (next_count != FULL_CNT);
		end
	end

	// data words, no reset needed
	always_ff @(posedge clk_sys_i) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule : tos_fifo

// time-stamped output scheduler top
module tos_scheduler (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic wide_window_i,
	input wire logic img_valid_i,
	input wire tos_pkg::tos_entry_t img_entry_i,
	output logic img_ready_o,
	output tos_pkg::tos_status_t status_o,
	output logic [tos_pkg::CHANNELS-1:0] dout_o,
	output logic [tos_pkg::CHANNELS-1:0] led_o
);
	// microsecond ticker
	logic [5:0] presc; // cycles inside one microsecond
	logic [31:0] ticker; // free-running microseconds

	// entry queue
	tos_pkg::tos_entry_t queue_mem [tos_pkg::QUEUE_SLOTS]; // queued entries
	logic [tos_pkg::QUEUE_AW-1:0] wr_ptr; // next free slot
	logic [tos_pkg::QUEUE_AW-1:0] rd_ptr; // entry to execute next
	logic [5:0] q_count; // entries held
	logic [5:0] term_cnt; // held entries flagged as terminator

	// window and sequence tracking
	logic [3:0] win_idx; // position inside current window
	logic skipping; // terminator seen in this window
	logic win_event; // something stored or refused this window
	logic [5:0] last_seq; // last accepted sequence
	logic [7:0] code; // queue code without terminator flag

	// ingress buffer drain side
	logic fq_valid; // buffered entry waiting
	tos_pkg::tos_entry_t fq_entry; // buffered entry

	// ticker decode
	wire tick_wrap = (presc == tos_pkg::TICK_LAST);
	wire [5:0] next_presc = tick_wrap ? 6'h00 : presc + 6'h01;
	wire [31:0] next_ticker = ticker + 32'(tick_wrap);

	// head of queue and due check
	wire tos_pkg::tos_entry_t head = queue_mem[rd_ptr];
	wire q_empty = (q_count == 6'h00);
	wire q_full = (q_count == tos_pkg::QUEUE_CAP);
	wire pop = !q_empty && (head.entry_time_value == ticker[15:0]); // RULE_01 RULE_19
	wire head_term = head.sequence_number[tos_pkg::SEQ_TERM_BIT];

	// drain stalls while an entry executes, so the buffer can fill
	wire take = fq_valid && !pop;
	wire [5:0] in_seq = fq_entry.sequence_number[5:0];
	wire in_term = fq_entry.sequence_number[tos_pkg::SEQ_TERM_BIT];
	wire [5:0] expected_seq = last_seq + 6'h01;
	wire seq_ok = (in_seq == expected_seq);

	// window bookkeeping
	wire [3:0] win_len = wide_window_i ? tos_pkg::WIN_LONG : tos_pkg::WIN_SHORT; // RULE_04
	wire win_end = take && (win_idx == win_len - 4'h1);
	wire [3:0] next_win_idx = win_end ? 4'h0 : win_idx + 4'(take);

	// entry decisions, in priority order
	wire ignored = take && skipping; // RULE_15
	wire refuse_full = take && !skipping && q_full; // RULE_06
	wire bad_seq = take && !skipping && !q_full && !seq_ok; // RULE_12
	wire push = take && !skipping && !q_full && seq_ok; // RULE_05
	wire starts_skip = take && !skipping && in_term; // RULE_15
	wire any_event = win_event || push || refuse_full || bad_seq;
	wire idle_window = win_end && !any_event;
	wire drained = pop && (q_count == 6'h01);

	// queue pointer and counter updates
	wire [tos_pkg::QUEUE_AW-1:0] next_wr_ptr = wr_ptr + {{(tos_pkg::QUEUE_AW-1){1'b0}}, push};
	wire [tos_pkg::QUEUE_AW-1:0] next_rd_ptr = rd_ptr + {{(tos_pkg::QUEUE_AW-1){1'b0}}, pop};
	wire [5:0] next_q_count = q_count + 6'(push) - 6'(pop); // RULE_03
	wire [5:0] term_add = 6'(push && in_term);
	wire [5:0] term_sub = 6'(pop && head_term);
	wire [5:0] next_term_cnt = term_cnt + term_add - term_sub;

	// queue code selection
	wire [7:0] next_code = push ? tos_pkg::CODE_OK // RULE_11
		: refuse_full ? tos_pkg::CODE_FULL // RULE_14
		: bad_seq ? tos_pkg::CODE_NONE // RULE_12
		: idle_window ? tos_pkg::CODE_IDLE // RULE_13
		: drained ? tos_pkg::CODE_NONE // RULE_12
		: code;

	// sequence bookkeeping
	wire [5:0] next_last_seq = push ? in_seq : last_seq;
	wire [5:0] next_exec_seq = q_empty ? expected_seq : head.sequence_number[5:0];
	wire skip_now = starts_skip || (skipping && !win_end);
	wire next_skipping = win_end ? 1'b0 : skip_now;
	wire next_win_event = win_end ? 1'b0 : any_event;

	// channel c takes output byte bit 7-c
	logic [tos_pkg::CHANNELS-1:0] head_levels;
	always_comb begin
		head_levels = '0;
		for (int c = 0; c < tos_pkg::CHANNELS; c++) begin
			head_levels[c] = head.output_state_byte[tos_pkg::OUT_CH0_BIT - c]; // RULE_20
		end
	end
	wire [tos_pkg::CHANNELS-1:0] next_dout = pop ? head_levels : dout_o; // RULE_21

	// terminator flag onto the code byte
	wire [7:0] term_or = (next_term_cnt != 6'h00) ? tos_pkg::TERM_FLAG : 8'h00;

	// four-byte input area
	tos_pkg::tos_status_t next_status;
	assign next_status.last_accepted_sequence = tos_pkg::LAST_FIX | {2'b00, next_last_seq}; // RULE_09
	assign next_status.next_executed_sequence = tos_pkg::NEXT_FIX | {2'b00, next_exec_seq}; // RULE_10
	assign next_status.queue_state_code = next_code | term_or; // RULE_16
	assign next_status.queued_entry_count = {2'b00, next_q_count}; // RULE_17

	// ingress buffer of four entries
	tos_fifo #(
		.WIDTH(tos_pkg::ENTRY_W),
		.DEPTH(tos_pkg::INGRESS_DEPTH)
	) u_ingress (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.in_valid_i(img_valid_i),
		.in_data_i(img_entry_i),
		.in_ready_o(img_ready_o),
		.out_valid_o(fq_valid),
		.out_data_o(fq_entry),
		.out_ready_i(!pop)
	);

	// microsecond ticker from reset, wraps naturally
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			presc <= 6'h00;
			ticker <= 32'h00000000;
		end else begin
			presc <= next_presc;
			ticker <= next_ticker; // RULE_19
		end
	end

	// queue pointers and counters
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			q_count <= 6'h00;
			term_cnt <= 6'h00;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			q_count <= next_q_count; // RULE_03
			term_cnt <= next_term_cnt; // RULE_16
		end
	end

	// queue storage, only accepted entries land here
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			queue_mem[wr_ptr] <= fq_entry; // RULE_05
		end
	end

	// window, sequence and code state
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			win_idx <= 4'h0;
			skipping <= 1'b0;
			win_event <= 1'b0;
			last_seq <= tos_pkg::SEQ_RESET;
			code <= tos_pkg::CODE_RESET;
		end else begin
			win_idx <= next_win_idx; // RULE_04
			skipping <= next_skipping; // RULE_15
			win_event <= next_win_event;
			last_seq <= next_last_seq;
			code <= next_code;
		end
	end

	// registered outputs: channels, lamps and status bytes
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dout_o <= tos_pkg::OUT_RESET;
			led_o <= tos_pkg::OUT_RESET;
			status_o <= '{
				last_accepted_sequence: tos_pkg::LAST_FIX,
				next_executed_sequence: tos_pkg::NEXT_FIX | 8'h01,
				queue_state_code: tos_pkg::CODE_RESET,
				queued_entry_count: 8'h00
			};
		end else begin
			dout_o <= next_dout; // RULE_01
			led_o <= next_dout; // RULE_02
			status_o <= next_status; // RULE_08
		end
	end
endmodule : tos_scheduler

/* File: verif/tos_host_model.sv */
`timescale 1ns/10ps
// host side: offers one entry, holds it until taken
module tos_host_model (
	input wire logic clk_i,
	input wire logic ready_i,
	output logic valid_o,
	output tos_pkg::tos_entry_t entry_o
);
	// idle at time zero
	initial begin
		valid_o = 1'b0;
		entry_o = '0;
	end
	// request held until ready seen at an edge
	task automatic send(input tos_pkg::tos_entry_t e);
		@(posedge clk_i);
		#1;
		valid_o = 1'b1;
		entry_o = e;
		@(posedge clk_i);
		while (ready_i !== 1'b1) @(posedge clk_i);
		#1;
		valid_o = 1'b0;
		entry_o = ~e; // released data no longer valid
	endtask : send
endmodule : tos_host_model

/* File: verif/tos_scheduler_monitor.sv */
`timescale 1ns/10ps
// port watcher for the scheduler top
module tos_scheduler_monitor (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic wide_window_i,
	input wire logic img_valid_i,
	input wire tos_pkg::tos_entry_t img_entry_i,
	input wire logic img_ready_o,
	input wire tos_pkg::tos_status_t status_o,
	input wire logic [tos_pkg::CHANNELS-1:0] dout_o,
	input wire logic [tos_pkg::CHANNELS-1:0] led_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire [7:0] cnt = status_o.queued_entry_count; // entries held
	wire [7:0] code = status_o.queue_state_code; // queue state code
	led_follow_a: assert property (led_o == dout_o)
		else $error("lamp differs from output");
	last_fixed_a: assert property (status_o[31:30] == 2'h1)
		else $error("last sequence fixed bits wrong");
	next_fixed_a: assert property (status_o[23:22] == 2'h3)
		else $error("next sequence fixed bits wrong");
	count_cap_a: assert property (cnt <= 8'h1F)
		else $error("count above capacity");
	count_step_a: assert property (!$stable(cnt) |-> cnt == $past(cnt) + 8'h01 || cnt == $past(cnt) - 8'h01)
		else $error("count jumped");
	full_code_a: assert property ($rose(code[1:0] == 2'h3) |-> cnt == 8'h1F)
		else $error("full code while not full");
	term_flag_a: assert property (code[7] |-> cnt != 8'h00)
		else $error("end flag on empty queue");
	idle_hold_a: assert property (cnt == 8'h00 [*3] |=> $stable(dout_o))
		else $error("outputs moved while empty");
	cover property (code == 8'h00 && cnt != 8'h00);
	cover property (code[1:0] == 2'h3);
	cover property (code[7]);
endmodule : tos_scheduler_monitor

/* File: verif/tos_scheduler_tb_top.sv */
`timescale 1ns/10ps
// bench for the time-stamped output scheduler
module tos_scheduler_tb_top;
	// one row: entry written, status expected after it
	typedef struct packed {
		tos_pkg::tos_entry_t e;
		tos_pkg::tos_status_t s;
	} tos_row_t;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b0; // raised just after time zero so the async reset sees an edge
	logic wide_window_i = 1'b1;
	logic img_valid_i;
	logic img_ready_o;
	tos_pkg::tos_entry_t img_entry_i;
	tos_pkg::tos_status_t status_o;
	logic [3:0] dout_o;
	logic [3:0] led_o;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0; // edges since release
	int tmo = 0; // hang guard
	tos_row_t rows [5] = '{
		64'hA0010020_41C10001, // first store
		64'h50020021_42C10002,
		64'h30030021_43C10003, // same stamp as previous
		64'hF0050021_43C10103, // skipped number refused
		64'hC0440022_44C18004 // end marker stored
	};
	tos_scheduler dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wide_window_i(wide_window_i),
		.img_valid_i(img_valid_i), .img_entry_i(img_entry_i), .img_ready_o(img_ready_o),
		.status_o(status_o), .dout_o(dout_o), .led_o(led_o));
	tos_host_model host (.clk_i(clk_sys_i), .ready_i(img_ready_o), .valid_o(img_valid_i),
		.entry_o(img_entry_i));
	always #12.5 clk_sys_i = ~clk_sys_i;
	// cycle count and timeout
	always @(posedge clk_sys_i) begin
		cyc <= rst_i ? 0 : cyc + 1;
		tmo <= tmo + 1;
		if (tmo == 5000) begin
			err_count++;
			give_verdict();
		end
	end
	// channel c takes output byte bit 7-c
	function automatic logic [3:0] outs(input logic [7:0] b);
		return {b[4], b[5], b[6], b[7]};
	endfunction : outs
	task automatic cmp_status(input tos_pkg::tos_status_t exp);
		cmp_count++;
		if (status_o !== exp) begin
			err_count++;
			$display("[FAIL] %0t status %h exp %h", $time, status_o, exp);
		end
	endtask : cmp_status
	task automatic cmp_dout(input logic [3:0] exp);
		cmp_count++;
		if (dout_o !== exp) begin
			err_count++;
			$display("[FAIL] %0t dout %h exp %h", $time, dout_o, exp);
		end
	endtask : cmp_dout
	task automatic cmp_ready(input logic exp);
		cmp_count++;
		if (img_ready_o !== exp) begin
			err_count++;
			$display("[FAIL] %0t ready %h exp %h", $time, img_ready_o, exp);
		end
	endtask : cmp_ready
	// write one entry, let status settle
	task automatic wr(input tos_pkg::tos_entry_t e);
		host.send(e);
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask : wr
	task automatic upto(input int n);
		while (cyc < n) @(posedge clk_sys_i);
		#1;
	endtask : upto
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// main sequence
	initial begin
		#1;
		rst_i = 1'b1;
		repeat (5) @(posedge clk_sys_i);
		#1;
		cmp_status(32'h40C10200);
		rst_i = 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].e);
			cmp_status(rows[i].s);
		end
		for (int i = 0; i < 10; i++)
			wr({8'hF0, 8'(i + 5), 16'h0030});
		cmp_status(32'h44C18004);
		upto(1275);
		cmp_dout(4'h0);
		upto(1290);
		cmp_dout(outs(8'hA0));
		upto(1400);
		cmp_dout(outs(8'hC0));
		cmp_status(32'h44C50100);
		wide_window_i = 1'b0;
		for (int i = 5; i < 36; i++)
			wr({8'h10, 8'(i), 16'h8000});
		cmp_status(32'h63C5001F);
		wr({8'h10, 8'h24, 16'h8000});
		cmp_status(32'h63C5031F);
		rst_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		cmp_status(32'h40C10200);
		cmp_dout(4'h0);
		cmp_ready(1'b0);
		rst_i = 1'b0;
		// sequence tracking restarts: number 1 is accepted again
		wr(rows[0].e);
		cmp_status(rows[0].s);
		cmp_ready(1'b1);
		give_verdict();
	end
endmodule : tos_scheduler_tb_top
bind tos_scheduler tos_scheduler_monitor mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.wide_window_i(wide_window_i), .img_valid_i(img_valid_i), .img_entry_i(img_entry_i),
	.img_ready_o(img_ready_o), .status_o(status_o), .dout_o(dout_o), .led_o(led_o));
